// >>> rtl/uart_rate_map.vh
// Register indices, fields, codes and rate constants of the rate block
`ifndef UART_RATE_MAP_VH
`define UART_RATE_MAP_VH
// Register indices; byte address is four times the index
`define IDX_MODE 4'h0
`define IDX_CSEL 4'h1
`define IDX_RTEST 4'h2
`define IDX_RXDATA 4'h3
`define IDX_AUX 4'h4
`define IDX_CMD 4'h5
`define IDX_STAT 4'h6
`define IDX_MASK 4'h7
`define IDX_OPORT 4'h8
`define IDX_XTEST 4'ha
// Field positions
`define AUX_SET_BIT 7
`define WAKE_HI 4
`define WAKE_LO 3
`define WAKE_ON 2'h3
`define CMD_RXRST 0
`define CMD_RXEN 1
`define CMD_RXDIS 2
// Status bits
`define ST_RXRDY 0
`define ST_FRAME 1
`define ST_BREAK 2
`define ST_FALSE 3
`define ST_W 4
// Clock select codes
`define CS_TIMER 4'hd
`define CS_EXT16 4'he
`define CS_EXT1 4'hf
// Oversampling
`define OVS_LAST 4'hf
`define OVS_MID 4'h7
`define DATA_LAST 3'h7
// Clock rate times ten, rates in tenths of a baud
`define CLK_X10 1000000000
`define DIV(r) (`CLK_X10 / (16 * (r)))
`define B50 500
`define B75 750
`define B110 1100
`define B134 1345
`define B150 1500
`define B200 2000
`define B300 3000
`define B600 6000
`define B880 8800
`define B1050 10500
`define B1076 10760
`define B1200 12000
`define B1800 18000
`define B2000 20000
`define B2400 24000
`define B4800 48000
`define B7200 72000
`define B9600 96000
`define B14K4 144000
`define B19K2 192000
`define B28K8 288000
`define B38K4 384000
`define B57K6 576000
`define B115K2 1152000
`endif

// >>> rtl/uart_rate_select.v
// Rate selection, receiver with noise filter and lock-up recovery, APB regs
// Operation
// - A 4-bit select code per direction picks a fixed rate from one of two sets by the rate-set bit, or the timer (1101), external 16x (1110) or external 1x (1111).
// - Every read at register index 2 toggles the rate test mode.
// - In rate test mode the test rate table replaces the fixed table for both directions.
// - Every access at register index A toggles the 1x test mode, which switches the receiver to 1x sampling and routes internal nodes to the output port.
// - With 16x sampling a noisy start bit returns the receiver to idle with the false-start bit set, and data that follows is received without a receiver reset.
// - Outside wake-up mode the host clears a lock-up by a receiver reset then a receiver enable, and data, status and mode survive the reset.
// - The receiver filters its input and rejects noise that looks like a start bit.
// - After a corrupted start bit the receiver realigns to the next zero bit on the line.
`timescale 1ns/1ps
`include "uart_rate_map.vh"
module uart_rate_select #(
  parameter DIV_W = 17
) (
  // Clock and reset
  input wire sys_clk,
  input wire nrst,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [5:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Line and clock pins
  input wire rxd,
  input wire ext_clock_pin,
  input wire timerTick,
  // Rate and port outputs
  output wire rxRateTick,
  output wire txRateTick,
  output reg [7:0] opPort,
  // Interrupt
  output wire irq
);

  localparam S_IDLE = 2'h0;
  localparam S_START = 2'h1;
  localparam S_DATA = 2'h2;
  localparam S_STOP = 2'h3;

  reg [7:0] mode_reg_one_q;
  reg [7:0] clock_select_reg_q;
  reg [7:0] aux_control_reg_q;
  reg [7:0] rxData_q;
  reg [`ST_W-1:0] status_q;
  reg [`ST_W-1:0] mask_q;
  reg [7:0] portReg_q;
  reg rateTest_q;
  reg oneXTest_q;
  reg rxEnable_q;
  reg [2:0] rxSync_q;
  reg [2:0] clkSync_q;
  reg [2:0] filt_q;
  reg [1:0] state_q;
  reg [3:0] tickCnt_q;
  reg [2:0] bitCnt_q;
  reg [7:0] shift_q;
  reg [`ST_W-1:0] evt_q;
  wire [3:0] idx;
  wire mapped;
  wire accEn;
  wire wrEn;
  wire rdEn;
  wire setupRd;
  wire rxLine;
  wire extEdge;
  wire rxReset;
  wire [1:0] rateTick;
  wire [1:0] oneX;
  wire sample;
  wire rxTick;
  wire rxOneX;
  wire [7:0] wbyte;

  // Bus decode
  assign idx = paddr[5:2];
  assign mapped = (paddr[1:0] == 2'h0) &&
    (idx <= `IDX_OPORT || idx == `IDX_XTEST);
  assign accEn = psel && penable;
  assign wrEn = accEn && pwrite && mapped;
  assign rdEn = accEn && !pwrite && mapped;
  assign setupRd = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = accEn && !mapped;
  assign wbyte = pwdata[7:0];

  // Rate table lookup
  function [31:0] rateDiv;
    input [3:0] code;
    input set;
    input test;
    reg [31:0] r;
    begin
      r = `B9600;
      case ({test, set, code})
        6'h00: r = `B50;
        6'h01: r = `B110;
        6'h02: r = `B134;
        6'h03: r = `B200;
        6'h04: r = `B300;
        6'h05: r = `B600;
        6'h06: r = `B1200;
        6'h07: r = `B1050;
        6'h08: r = `B2400;
        6'h09: r = `B4800;
        6'h0a: r = `B7200;
        6'h0b: r = `B9600;
        6'h0c: r = `B38K4;
        6'h10: r = `B75;
        6'h11: r = `B110;
        6'h12: r = `B38K4;
        6'h13: r = `B150;
        6'h14: r = `B300;
        6'h15: r = `B600;
        6'h16: r = `B1200;
        6'h17: r = `B2000;
        6'h18: r = `B2400;
        6'h19: r = `B4800;
        6'h1a: r = `B1800;
        6'h1b: r = `B9600;
        6'h1c: r = `B19K2;
        6'h20: r = `B4800;
        6'h21: r = `B880;
        6'h22: r = `B1076;
        6'h23: r = `B19K2;
        6'h24: r = `B28K8;
        6'h25: r = `B57K6;
        6'h26: r = `B115K2;
        6'h27: r = `B1050;
        6'h28: r = `B57K6;
        6'h29: r = `B4800;
        6'h2a: r = `B57K6;
        6'h2b: r = `B9600;
        6'h2c: r = `B38K4;
        6'h30: r = `B7200;
        6'h31: r = `B880;
        6'h32: r = `B38K4;
        6'h33: r = `B14K4;
        6'h34: r = `B28K8;
        6'h35: r = `B57K6;
        6'h36: r = `B115K2;
        6'h37: r = `B2000;
        6'h38: r = `B57K6;
        6'h39: r = `B4800;
        6'h3a: r = `B14K4;
        6'h3b: r = `B9600;
        6'h3c: r = `B19K2;
        default: r = `B9600;
      endcase
      rateDiv = `DIV(r);
    end
  endfunction

  // Pin synchronisers and external clock edge
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rxSync_q <= 3'h7;
      clkSync_q <= 3'h0;
    end else begin
      rxSync_q <= {rxSync_q[1:0], rxd};
      clkSync_q <= {clkSync_q[1:0], ext_clock_pin};
    end
  end
  assign extEdge = clkSync_q[1] && !clkSync_q[2];

  // Per-direction rate generator, 0 receive, 1 transmit
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : gRate
      reg [DIV_W-1:0] cnt_q;
      wire [3:0] code;
      wire [DIV_W-1:0] divLast;
      wire [31:0] divFull;
      wire fixed;
      assign code = g ? clock_select_reg_q[3:0] : clock_select_reg_q[7:4];
      assign divFull = rateDiv(code, aux_control_reg_q[`AUX_SET_BIT],
        rateTest_q);
      assign divLast = divFull[DIV_W-1:0] - {{(DIV_W-1){1'b0}}, 1'b1};
      assign fixed = code < `CS_TIMER;
      always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          cnt_q <= {DIV_W{1'b0}};
        end else if (!fixed || cnt_q >= divLast) begin
          cnt_q <= {DIV_W{1'b0}};
        end else begin
          cnt_q <= cnt_q + {{(DIV_W-1){1'b0}}, 1'b1};
        end
      end
      assign rateTick[g] = fixed ? (cnt_q >= divLast) :
        (code == `CS_TIMER) ? timerTick : extEdge;
      assign oneX[g] = (code == `CS_EXT1) || oneXTest_q;
    end
  endgenerate
  assign rxRateTick = rateTick[0];
  assign txRateTick = rateTick[1];
  assign rxTick = rateTick[0];
  assign rxOneX = oneX[0];

  // Majority filter on line samples
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      filt_q <= 3'h7;
    end else if (rxTick) begin
      filt_q <= {filt_q[1:0], rxSync_q[1]};
    end
  end
  assign rxLine = (filt_q[0] & filt_q[1]) | (filt_q[1] & filt_q[2]) |
    (filt_q[0] & filt_q[2]);

  // Receiver reset is held off while wake-up mode is selected
  assign rxReset = wrEn && idx == `IDX_CMD && wbyte[`CMD_RXRST] &&
    mode_reg_one_q[`WAKE_HI:`WAKE_LO] != `WAKE_ON;
  assign sample = rxOneX ? 1'b1 : (tickCnt_q == `OVS_LAST);

  // Receiver state machine
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      evt_q <= {`ST_W{1'b0}};
      state_q <= S_IDLE;
      tickCnt_q <= 4'h0;
      bitCnt_q <= 3'h0;
      shift_q <= 8'h00;
      rxData_q <= 8'h00;
    end else if (rxReset || !rxEnable_q) begin
      evt_q <= {`ST_W{1'b0}};
      state_q <= S_IDLE;
      tickCnt_q <= 4'h0;
      bitCnt_q <= 3'h0;
    end else if (rxTick) begin
      evt_q <= {`ST_W{1'b0}};
      tickCnt_q <= tickCnt_q + 4'h1;
      case (state_q)
        S_IDLE: begin
          tickCnt_q <= 4'h0;
          if (!rxLine) begin
            state_q <= rxOneX ? S_DATA : S_START;
          end
        end
        S_START: begin
          if (rxLine) begin
            state_q <= S_IDLE;
            evt_q[`ST_FALSE] <= 1'b1;
          end else if (tickCnt_q == `OVS_MID) begin
            state_q <= S_DATA;
            tickCnt_q <= 4'h0;
            bitCnt_q <= 3'h0;
          end
        end
        S_DATA: begin
          if (sample) begin
            shift_q <= {rxLine, shift_q[7:1]};
            bitCnt_q <= bitCnt_q + 3'h1;
            if (bitCnt_q == `DATA_LAST) begin
              state_q <= S_STOP;
            end
          end
        end
        S_STOP: begin
          if (sample) begin
            state_q <= S_IDLE;
            rxData_q <= shift_q;
            evt_q[`ST_RXRDY] <= 1'b1;
            evt_q[`ST_FRAME] <= !rxLine;
            evt_q[`ST_BREAK] <= !rxLine && shift_q == 8'h00;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end else begin
      evt_q <= {`ST_W{1'b0}};
    end
  end

  // Registers, test modes and sticky status
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      mode_reg_one_q <= 8'h00;
      clock_select_reg_q <= 8'h00;
      aux_control_reg_q <= 8'h00;
      mask_q <= {`ST_W{1'b0}};
      portReg_q <= 8'h00;
      status_q <= {`ST_W{1'b0}};
      rateTest_q <= 1'b0;
      oneXTest_q <= 1'b0;
      rxEnable_q <= 1'b0;
    end else begin
      if (wrEn) begin
        case (idx)
          `IDX_MODE: mode_reg_one_q <= wbyte;
          `IDX_CSEL: clock_select_reg_q <= wbyte;
          `IDX_AUX: aux_control_reg_q <= wbyte;
          `IDX_MASK: mask_q <= wbyte[`ST_W-1:0];
          `IDX_OPORT: portReg_q <= wbyte;
          default: portReg_q <= portReg_q;
        endcase
      end
      if (rdEn && idx == `IDX_RTEST) begin
        rateTest_q <= !rateTest_q;
      end
      if (accEn && mapped && idx == `IDX_XTEST) begin
        oneXTest_q <= !oneXTest_q;
      end
      if (rxReset || (wrEn && idx == `IDX_CMD && wbyte[`CMD_RXDIS])) begin
        rxEnable_q <= 1'b0;
      end else if (wrEn && idx == `IDX_CMD && wbyte[`CMD_RXEN]) begin
        rxEnable_q <= 1'b1;
      end
      // Read clears only the bits it reported, new events win
      if (rdEn && idx == `IDX_STAT) begin
        status_q <= (status_q & ~prdata[`ST_W-1:0]) | evt_q;
      end else begin
        status_q <= status_q | evt_q;
      end
    end
  end

  // Read data captured in the setup phase
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      prdata <= 32'h0;
    end else if (setupRd) begin
      case (mapped ? idx : 4'hf)
        `IDX_MODE: prdata <= {24'h0, mode_reg_one_q};
        `IDX_CSEL: prdata <= {24'h0, clock_select_reg_q};
        `IDX_RXDATA: prdata <= {24'h0, rxData_q};
        `IDX_AUX: prdata <= {24'h0, aux_control_reg_q};
        `IDX_STAT: prdata <= {{(32-`ST_W){1'b0}}, status_q};
        `IDX_MASK: prdata <= {{(32-`ST_W){1'b0}}, mask_q};
        `IDX_OPORT: prdata <= {24'h0, portReg_q};
        default: prdata <= 32'h0;
      endcase
    end
  end

  // Output port, internal nodes in the 1x test mode
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      opPort <= 8'h00;
    end else if (oneXTest_q) begin
      opPort <= {rxTick, rxLine, state_q, tickCnt_q};
    end else begin
      opPort <= portReg_q;
    end
  end

  assign irq = |(status_q & mask_q);

endmodule // uart_rate_select

// >>> verif/uart_rate_select_monitor.sv
// Port checker of the rate block
`timescale 1ns/1ps
`include "uart_rate_map.vh"
module uart_rate_select_monitor (
  // Clock and reset
  input wire sys_clk,
  input wire nrst,
  // APB
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [5:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Pins
  input wire rxd,
  input wire ext_clock_pin,
  input wire timerTick,
  input wire rxRateTick,
  input wire txRateTick,
  input wire [7:0] opPort,
  input wire irq
);
  wire acc = psel && penable;
  wire [3:0] idx = paddr[5:2];
  wire unm = paddr[1:0] != 2'h0 || idx == 4'h9 || idx > 4'ha;
  wire wr = acc && pwrite && !unm;
  wire rd = acc && !pwrite && !unm;
  wire cfg = acc && (idx == `IDX_CSEL || idx == `IDX_RTEST ||
    idx == `IDX_AUX || idx == `IDX_XTEST);
  reg [7:0] cselQ;
  reg [3:0] maskQ;
  reg testQ;
  reg xQ;
  reg okQ;
  reg [12:0] gapQ;
  reg [3:0] quietQ;
  // Shadow of the programming seen on the bus
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cselQ <= 8'h00;
      maskQ <= 4'h0;
      testQ <= 1'b0;
      xQ <= 1'b0;
      okQ <= 1'b0;
      gapQ <= 13'h0000;
      quietQ <= 4'h0;
    end else begin
      if (wr && idx == `IDX_CSEL)
        cselQ <= pwdata[7:0];
      if (wr && idx == `IDX_MASK)
        maskQ <= pwdata[3:0];
      if (rd && idx == `IDX_RTEST)
        testQ <= !testQ;
      if (acc && !unm && idx == `IDX_XTEST)
        xQ <= !xQ;
      okQ <= cfg ? 1'b0 : (okQ || rxRateTick);
      gapQ <= rxRateTick ? 13'h0000 : gapQ + 13'h0001;
      if (cfg || timerTick || ext_clock_pin != $past(ext_clock_pin))
        quietQ <= 4'h0;
      else if (quietQ != 4'hf)
        quietQ <= quietQ + 4'h1;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  a_ready_high: assert property (pready) else $error("pready low");
  a_unmapped_err: assert property (acc && unm |->
    pslverr && (pwrite || prdata == 0))
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (acc && !unm |-> !pslverr)
    else $error("mapped access refused");
  a_rtest_zero: assert property (rd && idx == `IDX_RTEST |-> prdata == 0)
    else $error("rate test read not zero");
  a_csel_kept: assert property (rd && idx == `IDX_CSEL |->
    prdata == {24'h000000, cselQ}) else $error("select code lost");
  a_rate_gap: assert property (rxRateTick && okQ && !xQ &&
    cselQ[7:4] == 4'h6 |-> gapQ == (testQ ? 13'h0035 : 13'h1457))
    else $error("rx tick period wrong");
  a_ext_quiet: assert property (cselQ[7:4] >= `CS_TIMER &&
    quietQ > 4'h6 |-> !rxRateTick) else $error("tick without source");
  a_ext1_tick: assert property (cselQ[7:4] == `CS_EXT1 &&
    $rose(ext_clock_pin) |-> ##[1:6] rxRateTick)
    else $error("ext edge gave no tick");
  a_timer_tick: assert property (cselQ[7:4] == `CS_TIMER &&
    timerTick |-> ##[0:3] rxRateTick) else $error("timer gave no tick");
  a_irq_masked: assert property (maskQ == 4'h0 |-> !irq)
    else $error("irq with all masked");
  a_rxrst_keep: assert property (wr && idx == `IDX_CMD &&
    pwdata[0] |=> irq == $past(irq)) else $error("rx reset lost status");
endmodule // uart_rate_select_monitor
bind uart_rate_select uart_rate_select_monitor i_uart_rate_select_monitor (
  .sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .rxd(rxd),
  .ext_clock_pin(ext_clock_pin), .timerTick(timerTick),
  .rxRateTick(rxRateTick), .txRateTick(txRateTick), .opPort(opPort),
  .irq(irq));

// >>> verif/apb_host_model.sv
// Host model driving the APB register bus
`timescale 1ns/1ps
module apb_host_model (
  // Clock
  input wire sys_clk,
  // APB master side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [5:0] paddr,
  output logic [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 6'h00;
    pwdata = 32'h00000000;
  end
  // One transfer, held until pready is seen high
  task automatic xfer(input logic w, input logic [3:0] idx,
      input logic [7:0] wd, output logic [31:0] rdat, output logic err);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= {24'h000000, wd};
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (!pready)
      @(posedge sys_clk);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~pwdata;
  endtask
endmodule // apb_host_model

// >>> verif/uart_rate_select_bench.sv
// Self-checking bench of the rate block
`timescale 1ns/1ps
`include "uart_rate_map.vh"
module uart_rate_select_bench;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic rxd = 1'b1;
  logic ext_clock_pin = 1'b0;
  logic timerTick = 1'b0;
  logic tickOn = 1'b0;
  logic [1:0] ph = 2'h0;
  wire psel, penable, pwrite, pready, pslverr, rxRateTick, txRateTick, irq;
  wire [5:0] paddr;
  wire [31:0] pwdata, prdata;
  wire [7:0] opPort;
  logic [31:0] rdat;
  logic err;
  int rxCnt = 0;
  int txCnt = 0;
  int n_fail = 0;
  int n_tests = 0;
  always #5 sys_clk = !sys_clk;
  // Timer source and tick counters
  always @(posedge sys_clk) begin
    ph <= ph + 2'h1;
    timerTick <= tickOn && ph == 2'h3;
    rxCnt <= rxCnt + rxRateTick;
    txCnt <= txCnt + txRateTick;
  end
  uart_rate_select i_uart_rate_select (.sys_clk(sys_clk), .nrst(nrst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxd(rxd), .ext_clock_pin(ext_clock_pin), .timerTick(timerTick),
    .rxRateTick(rxRateTick), .txRateTick(txRateTick), .opPort(opPort),
    .irq(irq));
  apb_host_model i_apb_host_model (.sys_clk(sys_clk), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    i_apb_host_model.xfer(1'b1, a, d, rdat, err);
  endtask
  task automatic rd(input logic [3:0] a);
    i_apb_host_model.xfer(1'b0, a, 8'h00, rdat, err);
  endtask
  // Period of a full tick interval, after one settling interval
  task automatic gap(input logic tx, input logic [31:0] exp);
    int n;
    repeat (2) @(posedge sys_clk iff (tx ? txRateTick : rxRateTick));
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (!(tx ? txRateTick : rxRateTick) && n < 20000);
    chk(n, exp);
  endtask
  task automatic send(input logic [7:0] b);
    rxd <= 1'b0;
    repeat (64) @(posedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      rxd <= b[i];
      repeat (64) @(posedge sys_clk);
    end
    rxd <= 1'b1;
    repeat (96) @(posedge sys_clk);
  endtask
  task automatic t_rates;
    wr(`IDX_CSEL, 8'h66);
    gap(1'b0, 32'h1458);
    rd(`IDX_RTEST);
    chk(rdat, 32'h0);
    gap(1'b0, 32'h36);
    gap(1'b1, 32'h36);
    wr(`IDX_CSEL, 8'h00);
    gap(1'b0, 32'h516);
    wr(`IDX_AUX, 8'h80);
    gap(1'b1, 32'h364);
    wr(`IDX_AUX, 8'h00);
    rd(`IDX_RTEST);
    wr(`IDX_CSEL, 8'hcc);
    gap(1'b0, 32'ha2);
    $display("rates done");
  endtask
  task automatic t_ext;
    int r0;
    int t0;
    for (int i = 0; i < 3; i++) begin
      wr(`IDX_CSEL, {2{`CS_TIMER + 4'(i)}});
      r0 = rxCnt;
      t0 = txCnt;
      tickOn <= (i == 0);
      repeat (20) @(posedge sys_clk);
      tickOn <= 1'b0;
      repeat (10 * (i != 0)) begin
        repeat (8) @(posedge sys_clk);
        ext_clock_pin <= !ext_clock_pin;
      end
      repeat (12) @(posedge sys_clk);
      chk(rxCnt - r0, 32'h5);
      chk(txCnt - t0, 32'h5);
    end
    $display("ext done");
  endtask
  task automatic t_rx;
    wr(`IDX_CSEL, 8'hdd);
    tickOn <= 1'b1;
    wr(`IDX_MASK, 8'h01);
    wr(`IDX_CMD, 8'h02);
    rxd <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rxd <= 1'b1;
    repeat (200) @(posedge sys_clk);
    rd(`IDX_STAT);
    chk(rdat, 32'h0);
    rxd <= 1'b0;
    repeat (20) @(posedge sys_clk);
    rxd <= 1'b1;
    repeat (200) @(posedge sys_clk);
    rd(`IDX_STAT);
    chk(rdat, 32'h8);
    send(8'h3c);
    chk(irq, 32'h1);
    wr(`IDX_CMD, 8'h01);
    chk(irq, 32'h1);
    wr(`IDX_CMD, 8'h02);
    rd(`IDX_RXDATA);
    chk(rdat, 32'h3c);
    rd(`IDX_STAT);
    chk(rdat, 32'h1);
    @(posedge sys_clk);
    chk(irq, 32'h0);
    rxd <= 1'b0;
    repeat (640) @(posedge sys_clk);
    rxd <= 1'b1;
    repeat (96) @(posedge sys_clk);
    wr(`IDX_CMD, 8'h01);
    wr(`IDX_CMD, 8'h02);
    rd(`IDX_STAT);
    chk(rdat & 32'h7, 32'h7);
    send(8'ha5);
    rd(`IDX_RXDATA);
    chk(rdat, 32'ha5);
    rd(`IDX_STAT);
    chk(rdat, 32'h1);
    wr(`IDX_MODE, 8'h18);
    wr(`IDX_MODE, 8'h10);
    wr(`IDX_CMD, 8'h01);
    wr(`IDX_MODE, 8'h18);
    rd(`IDX_MODE);
    chk(rdat[4:3], 32'h3);
    send(8'h11);
    rd(`IDX_STAT);
    chk(rdat, 32'h0);
    $display("rx done");
  endtask
  task automatic t_misc;
    wr(`IDX_OPORT, 8'ha5);
    rd(4'h9);
    chk(err, 32'h1);
    chk(rdat, 32'h0);
    rd(`IDX_XTEST);
    repeat (8) @(posedge sys_clk);
    chk(opPort[6], 32'h1);
    rd(`IDX_XTEST);
    repeat (4) @(posedge sys_clk);
    chk(opPort, 32'ha5);
    $display("misc done");
  endtask
  task automatic summarize;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    t_rates;
    t_ext;
    t_rx;
    t_misc;
    summarize;
  end
  initial begin
    repeat (90000) @(posedge sys_clk);
    n_fail++;
    summarize;
  end
endmodule // uart_rate_select_bench
